// ===== verilog/flash_cmd_params.svh
`ifndef FLASH_CMD_PARAMS_SVH
`define FLASH_CMD_PARAMS_SVH

// Opcodes
`define FLASH_OPC_SET_WL 8'h06
`define FLASH_OPC_CLR_WL 8'h04
`define FLASH_OPC_JEDEC 8'h9f
`define FLASH_OPC_RD_STAT 8'h05
`define FLASH_OPC_WR_STAT 8'h01
`define FLASH_OPC_READ 8'h03
`define FLASH_OPC_QREAD 8'h0b
`define FLASH_OPC_REGION 8'h20
`define FLASH_OPC_ARR_A 8'h52
`define FLASH_OPC_ARR_B 8'hd8
`define FLASH_OPC_FULL_A 8'h60
`define FLASH_OPC_FULL_B 8'hc7
`define FLASH_OPC_PAGE 8'h02
`define FLASH_OPC_SLP_IN 8'hb9
`define FLASH_OPC_SLP_OUT 8'hab
`define FLASH_OPC_MAKER 8'h90

// Order select byte values of the maker/device id read
`define FLASH_ID_ORDER_MFR 8'h00
`define FLASH_ID_ORDER_DEV 8'h01

// Frame lengths in bytes, opcode included
`define FLASH_LEN_SHORT 3'h1
`define FLASH_LEN_WR_STAT 3'h2
`define FLASH_LEN_ADDR 3'h4
`define FLASH_LEN_QREAD 3'h5

// Sector select field of the address
`define FLASH_SECT_MSB 15
`define FLASH_SECT_LSB 12

// Reset value of the write latch
`define FLASH_WL_RESET 1'b0

// Busy time of a program, erase or status write
`define FLASH_OP_TIME_NS 20000
`define FLASH_CLK_PERIOD_NS 10
`define FLASH_OP_CYCLES ((`FLASH_OP_TIME_NS) / (`FLASH_CLK_PERIOD_NS))

`endif

// ===== verilog/flash_cmd_pkg.sv
`default_nettype none
package flash_cmd_pkg;

    // Decoder phases
    typedef enum logic [1:0] {
        ST_STANDBY = 2'b00,
        ST_CMD = 2'b01,
        ST_OUT = 2'b10,
        ST_IGNORE = 2'b11
    } dec_st_t;

    // Operation handed to the array data path
    typedef enum logic [2:0] {
        OPK_NONE = 3'b000,
        OPK_WR_STATUS = 3'b001,
        OPK_PAGE = 3'b010,
        OPK_REGION = 3'b011,
        OPK_ARRAY = 3'b100,
        OPK_FULL = 3'b101
    } op_kind_t;

    // Whole state of the decoder
    typedef struct packed {
        dec_st_t st;
        logic cs_q;
        logic sclk_q;
        logic [7:0] sh;
        logic [2:0] bit_cnt;
        logic [2:0] byte_cnt;
        logic [7:0] op;
        logic [23:0] addr;
        logic sel;
        logic [7:0] wdat;
        logic [7:0] obyte;
        logic [2:0] ocnt;
        logic [1:0] oidx;
        logic so;
        logic so_oe;
        logic wl;
        logic active;
        logic sleep;
        logic start;
        op_kind_t kind;
        logic [3:0] sector;
        logic wr_stb;
    } dec_state_t;

endpackage : flash_cmd_pkg
`default_nettype wire

// ===== verilog/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    // Two stages per pin; stage 0 feeds stage 1 only
    logic [1:0][W-1:0] stg_reg;
    logic [1:0][W-1:0] stg_next;

    generate
        if (W < 1) begin : g_bad_width
            $error("pin_sync needs at least one pin");
        end
    endgenerate

    // Shift each pin one stage along
    always_comb begin : p_next
        stg_next = {stg_reg[0], d_i};
    end

    // Synchronous reset to the idle pin levels
    always_ff @(posedge clk_i) begin : p_reg
        if (!rst_b_i) begin
            stg_reg <= {RST_VAL, RST_VAL};
        end else begin
            stg_reg <= stg_next;
        end
    end

    assign q_o = stg_reg[1];

endmodule : pin_sync
`default_nettype wire

// ===== verilog/busy_timer.sv
`timescale 1ns/10ps
`default_nettype none
module busy_timer #(
    parameter int CYCLES = 2000
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    output logic busy_o
);

    localparam int CW = $clog2(CYCLES + 1);

    // Busy flag on top, remaining cycles below
    logic [CW:0] st_reg;
    logic [CW:0] st_next;

    generate
        if (CYCLES < 1) begin : g_bad_cycles
            $error("busy_timer needs at least one cycle");
        end
    endgenerate

    // A start restarts the count even while busy
    always_comb begin : p_next
        st_next = st_reg;
        if (start_i) begin
            st_next = {1'b1, CW'(CYCLES)};
        end else if (st_reg[CW-1:0] == CW'(1)) begin
            st_next = '0;
        end else if (st_reg[CW]) begin
            st_next[CW-1:0] = st_reg[CW-1:0] - CW'(1);
        end
    end

    always_ff @(posedge clk_i) begin : p_reg
        if (!rst_b_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy_o = st_reg[CW];

endmodule : busy_timer
`default_nettype wire

// ===== verilog/spi_flash_cmd_decoder.sv
`timescale 1ns/10ps
`default_nettype none
`include "flash_cmd_params.svh"
module spi_flash_cmd_decoder #(
    parameter int OP_CYCLES = `FLASH_OP_CYCLES,
    parameter logic [7:0] MFR_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] MEM_TYPE_CODE = 8'h3c, // Arbitrary value
    parameter logic [7:0] CAPACITY_CODE = 8'h0e, // Arbitrary value
    parameter logic [7:0] LEGACY_DEV_CODE = 8'h0d // Arbitrary value
) (
    input wire logic CLK_SYS_I,
    input wire logic RST_B_I,
    input wire logic CS_B_I,
    input wire logic SCLK_I,
    input wire logic SI_I,
    input wire logic [5:0] STATUS_UPPER_I,
    input wire logic [7:0] RD_DATA_I,
    output logic SO_O,
    output logic SO_OE_O,
    output logic WRITE_LATCH_O,
    output logic BUSY_FLAG_O,
    output logic ACTIVE_O,
    output logic SLEEP_O,
    output logic OP_START_O,
    output logic [2:0] OP_KIND_O,
    output logic [23:0] ADDR_O,
    output logic [3:0] SECTOR_O,
    output logic [7:0] WR_DATA_O,
    output logic WR_STB_O
);

    flash_cmd_pkg::dec_state_t r;
    flash_cmd_pkg::dec_state_t n;
    logic cs_s;
    logic sclk_s;
    logic si_s;
    logic [2:0] pins_s;
    logic busy;
    logic cs_rise;
    logic cs_fall;
    logic sclk_rise;
    logic sclk_fall;

    generate
        if (OP_CYCLES < 1) begin : g_bad_cycles
            $error("OP_CYCLES must be at least one");
        end
    endgenerate

    // Opcodes the device knows at all
    function automatic logic known_op(input logic [7:0] op);
        case (op)
            `FLASH_OPC_SET_WL, `FLASH_OPC_CLR_WL, `FLASH_OPC_JEDEC,
            `FLASH_OPC_RD_STAT, `FLASH_OPC_WR_STAT, `FLASH_OPC_READ,
            `FLASH_OPC_QREAD, `FLASH_OPC_REGION, `FLASH_OPC_ARR_A,
            `FLASH_OPC_ARR_B, `FLASH_OPC_FULL_A, `FLASH_OPC_FULL_B,
            `FLASH_OPC_PAGE, `FLASH_OPC_SLP_IN, `FLASH_OPC_SLP_OUT,
            `FLASH_OPC_MAKER: known_op = 1'b1;
            default: known_op = 1'b0;
        endcase
    endfunction : known_op

    // Commands that change content and need the write latch
    function automatic logic needs_wl(input logic [7:0] op);
        case (op)
            `FLASH_OPC_WR_STAT, `FLASH_OPC_PAGE, `FLASH_OPC_REGION,
            `FLASH_OPC_ARR_A, `FLASH_OPC_ARR_B, `FLASH_OPC_FULL_A,
            `FLASH_OPC_FULL_B: needs_wl = 1'b1;
            default: needs_wl = 1'b0;
        endcase
    endfunction : needs_wl

    // Byte count after which output starts, zero for none
    function automatic logic [2:0] out_start(input logic [7:0] op);
        case (op)
            `FLASH_OPC_RD_STAT, `FLASH_OPC_JEDEC: out_start = `FLASH_LEN_SHORT;
            `FLASH_OPC_READ, `FLASH_OPC_MAKER,
            `FLASH_OPC_SLP_OUT: out_start = `FLASH_LEN_ADDR;
            `FLASH_OPC_QREAD: out_start = `FLASH_LEN_QREAD;
            default: out_start = 3'h0;
        endcase
    endfunction : out_start

    // Frame length that lets a command execute; page needs more than four bytes
    function automatic logic exec_ok(input logic [7:0] op,
                                     input logic [2:0] nb);
        case (op)
            `FLASH_OPC_SET_WL, `FLASH_OPC_CLR_WL, `FLASH_OPC_FULL_A,
            `FLASH_OPC_FULL_B, `FLASH_OPC_SLP_IN,
            `FLASH_OPC_SLP_OUT: exec_ok = (nb == `FLASH_LEN_SHORT);
            `FLASH_OPC_WR_STAT: exec_ok = (nb == `FLASH_LEN_WR_STAT);
            `FLASH_OPC_REGION, `FLASH_OPC_ARR_A,
            `FLASH_OPC_ARR_B: exec_ok = (nb == `FLASH_LEN_ADDR);
            `FLASH_OPC_PAGE: exec_ok = (nb > `FLASH_LEN_ADDR);
            default: exec_ok = 1'b0;
        endcase
    endfunction : exec_ok

    // Operation kind passed to the data path
    function automatic flash_cmd_pkg::op_kind_t kind_of(input logic [7:0] op);
        case (op)
            `FLASH_OPC_WR_STAT: kind_of = flash_cmd_pkg::OPK_WR_STATUS;
            `FLASH_OPC_PAGE: kind_of = flash_cmd_pkg::OPK_PAGE;
            `FLASH_OPC_REGION: kind_of = flash_cmd_pkg::OPK_REGION;
            `FLASH_OPC_ARR_A, `FLASH_OPC_ARR_B: kind_of = flash_cmd_pkg::OPK_ARRAY;
            `FLASH_OPC_FULL_A, `FLASH_OPC_FULL_B: kind_of = flash_cmd_pkg::OPK_FULL;
            default: kind_of = flash_cmd_pkg::OPK_NONE;
        endcase
    endfunction : kind_of

    // Opcode admission; sleep lets only the wake opcode through
    function automatic logic accept(input logic [7:0] op, input logic bsy,
                                    input logic wl, input logic slp);
        if (slp) begin
            accept = (op == `FLASH_OPC_SLP_OUT);
        end else if (!known_op(op)) begin
            accept = 1'b0;
        end else if (bsy && (needs_wl(op) || op == `FLASH_OPC_READ ||
                 op == `FLASH_OPC_QREAD || op == `FLASH_OPC_JEDEC)) begin
            accept = 1'b0;
        end else begin
            accept = !(needs_wl(op) && !wl);
        end
    endfunction : accept

    // Next byte of an output phase
    function automatic logic [7:0] out_byte(input logic [7:0] op,
        input logic [1:0] idx, input logic sel, input logic [7:0] stat,
        input logic [7:0] rd);
        case (op)
            `FLASH_OPC_RD_STAT: out_byte = stat;
            `FLASH_OPC_READ, `FLASH_OPC_QREAD: out_byte = rd;
            `FLASH_OPC_JEDEC: begin
                case (idx)
                    2'h0: out_byte = MFR_CODE;
                    2'h1: out_byte = MEM_TYPE_CODE;
                    2'h2: out_byte = CAPACITY_CODE;
                    default: out_byte = 8'h00;
                endcase
            end
            `FLASH_OPC_MAKER: begin
                out_byte = (idx[0] ^ sel) ? LEGACY_DEV_CODE : MFR_CODE;
            end
            `FLASH_OPC_SLP_OUT: out_byte = LEGACY_DEV_CODE;
            default: out_byte = 8'h00;
        endcase
    endfunction : out_byte

    // CS idles high, so its stages reset to one
    pin_sync #(
        .W(3),
        .RST_VAL(3'h4)
    ) u_pin_sync (
        .clk_i(CLK_SYS_I),
        .rst_b_i(RST_B_I),
        .d_i({CS_B_I, SCLK_I, SI_I}),
        .q_o(pins_s)
    );

    // Timer stands in for the array's program and erase time
    busy_timer #(
        .CYCLES(OP_CYCLES)
    ) u_busy_timer (
        .clk_i(CLK_SYS_I),
        .rst_b_i(RST_B_I),
        .start_i(r.start),
        .busy_o(busy)
    );

    // Edges of the sampled pins; either SCLK idle level works
    assign cs_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign si_s = pins_s[0];
    assign cs_rise = cs_s & ~r.cs_q;
    assign cs_fall = ~cs_s & r.cs_q;
    assign sclk_rise = sclk_s & ~r.sclk_q;
    assign sclk_fall = ~sclk_s & r.sclk_q;

    // Frame decoder
    always_comb begin : p_next
        logic [7:0] byte_in;
        logic [7:0] op_now;
        logic [7:0] ob;
        byte_in = {r.sh[6:0], si_s};
        op_now = (r.byte_cnt == 3'h0) ? byte_in : r.op;
        ob = 8'h00;
        n = r;
        n.start = 1'b0;
        n.wr_stb = 1'b0;
        n.cs_q = cs_s;
        n.sclk_q = sclk_s;
        if (cs_s) begin
            // Partial bytes fail here, so the command is dropped
            if (cs_rise && r.st == flash_cmd_pkg::ST_CMD &&
                r.bit_cnt == 3'h0 && exec_ok(r.op, r.byte_cnt)) begin
                case (r.op)
                    `FLASH_OPC_SET_WL: n.wl = 1'b1;
                    `FLASH_OPC_CLR_WL: n.wl = 1'b0;
                    `FLASH_OPC_SLP_IN: n.sleep = 1'b1;
                    `FLASH_OPC_SLP_OUT: n.sleep = 1'b0;
                    default: begin
                        n.start = 1'b1;
                        n.kind = kind_of(r.op);
                        n.wl = 1'b0;
                        n.sector = r.addr[`FLASH_SECT_MSB:`FLASH_SECT_LSB];
                    end
                endcase
            end
            // Read frames end here at any bit without executing
            n.st = flash_cmd_pkg::ST_STANDBY;
            n.so_oe = 1'b0;
            n.active = 1'b0;
        end else if (cs_fall) begin
            n.st = flash_cmd_pkg::ST_CMD;
            n.bit_cnt = 3'h0;
            n.byte_cnt = 3'h0;
            n.ocnt = 3'h0;
            n.oidx = 2'h0;
        end else begin
            case (r.st)
                flash_cmd_pkg::ST_CMD: begin
                    if (sclk_rise) begin
                        n.sh = byte_in;
                        n.bit_cnt = r.bit_cnt + 3'h1;
                    end
                    if (sclk_rise && r.bit_cnt == 3'h7) begin
                        // Count saturates; long page frames stay valid
                        if (r.byte_cnt != 3'h7) begin
                            n.byte_cnt = r.byte_cnt + 3'h1;
                        end
                        if (r.byte_cnt == 3'h0) begin
                            n.op = byte_in;
                            if (accept(byte_in, busy, r.wl, r.sleep)) begin
                                n.active = 1'b1;
                            end else begin
                                n.st = flash_cmd_pkg::ST_IGNORE;
                            end
                        end else begin
                            if (r.byte_cnt < `FLASH_LEN_ADDR) begin
                                n.addr = {r.addr[15:0], byte_in};
                            end
                            if (r.op == `FLASH_OPC_MAKER &&
                                r.byte_cnt == 3'h3) begin
                                n.sel = byte_in[0];
                            end
                            if (r.op == `FLASH_OPC_WR_STAT ||
                                (r.op == `FLASH_OPC_PAGE &&
                                 r.byte_cnt >= `FLASH_LEN_ADDR)) begin
                                n.wdat = byte_in;
                                n.wr_stb = 1'b1;
                            end
                        end
                        // Zero means no output; the 3-bit sum wraps at 7
                        if (n.st == flash_cmd_pkg::ST_CMD &&
                            out_start(op_now) != 3'h0 &&
                            out_start(op_now) == r.byte_cnt + 3'h1) begin
                            n.st = flash_cmd_pkg::ST_OUT;
                        end
                    end
                end
                flash_cmd_pkg::ST_OUT: begin
                    // SO only moves on the falling edge
                    if (sclk_fall) begin
                        n.so_oe = 1'b1;
                        n.ocnt = r.ocnt + 3'h1;
                        if (r.ocnt == 3'h0) begin
                            ob = out_byte(r.op, r.oidx, r.sel,
                                {STATUS_UPPER_I, r.wl, busy}, RD_DATA_I);
                            n.so = ob[7];
                            n.obyte = {ob[6:0], 1'b0};
                            if (r.oidx != 2'h3) begin
                                n.oidx = r.oidx + 2'h1;
                            end
                            if (r.op == `FLASH_OPC_READ ||
                                r.op == `FLASH_OPC_QREAD) begin
                                n.addr = r.addr + 24'h1;
                            end
                        end else begin
                            n.so = r.obyte[7];
                            n.obyte = {r.obyte[6:0], 1'b0};
                        end
                    end
                end
                default: begin
                    // Standby and ignore wait for CS
                end
            endcase
        end
    end

    // Whole state registered at once
    always_ff @(posedge CLK_SYS_I) begin : p_reg
        if (!RST_B_I) begin
            r <= '0;
            r.cs_q <= 1'b1;
            r.wl <= `FLASH_WL_RESET;
        end else begin
            r <= n;
        end
    end

    assign SO_O = r.so;
    assign SO_OE_O = r.so_oe;
    assign WRITE_LATCH_O = r.wl;
    assign BUSY_FLAG_O = busy;
    assign ACTIVE_O = r.active;
    assign SLEEP_O = r.sleep;
    assign OP_START_O = r.start;
    assign OP_KIND_O = r.kind;
    assign ADDR_O = r.addr;
    assign SECTOR_O = r.sector;
    assign WR_DATA_O = r.wdat;
    assign WR_STB_O = r.wr_stb;

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RST_B_I);

    sequence s_exec(logic [7:0] code);
        cs_rise && r.st == flash_cmd_pkg::ST_CMD && r.bit_cnt == 3'h0 &&
        r.byte_cnt == 3'h1 && r.op == code;
    endsequence

    sequence s_opcode_done(logic [7:0] code);
        r.st == flash_cmd_pkg::ST_CMD && !cs_s && !cs_fall && sclk_rise &&
        r.bit_cnt == 3'h7 && r.byte_cnt == 3'h0 &&
        {r.sh[6:0], si_s} == code;
    endsequence

    AST_SET_WL: assert property (s_exec(`FLASH_OPC_SET_WL) |=> WRITE_LATCH_O)
        else $error("write latch not set");
    AST_CLR_WL: assert property (s_exec(`FLASH_OPC_CLR_WL) |=> !WRITE_LATCH_O)
        else $error("write latch not cleared");
    AST_WL_DROP: assert property (OP_START_O |-> !WRITE_LATCH_O)
        else $error("latch still set at operation start");
    AST_BUSY_START: assert property (OP_START_O |=> BUSY_FLAG_O)
        else $error("busy flag not raised");
    AST_ID_BUSY: assert property (s_opcode_done(`FLASH_OPC_JEDEC) ##0 busy
        |=> r.st == flash_cmd_pkg::ST_IGNORE)
        else $error("identity decoded while busy");
    AST_IGNORE_HOLD: assert property (r.st == flash_cmd_pkg::ST_IGNORE &&
        !cs_s |=> r.st == flash_cmd_pkg::ST_IGNORE)
        else $error("left ignore without CS");
    AST_HIZ: assert property (r.st inside {flash_cmd_pkg::ST_STANDBY,
        flash_cmd_pkg::ST_IGNORE} |-> !SO_OE_O)
        else $error("SO driven in standby");
    AST_ACTIVE: assert property (ACTIVE_O && !cs_s |=> ACTIVE_O)
        else $error("active dropped before CS rise");
    AST_SO_FALL: assert property (!$stable(SO_O) |-> $past(sclk_fall))
        else $error("SO moved off a falling edge");
    AST_BOUNDARY: assert property (cs_rise && r.bit_cnt != 3'h0
        |=> !OP_START_O && $stable(WRITE_LATCH_O))
        else $error("command ran off byte boundary");
    AST_JEDEC_FIRST: assert property (r.st == flash_cmd_pkg::ST_OUT &&
        r.op == `FLASH_OPC_JEDEC && sclk_fall && !cs_s &&
        r.ocnt == 3'h0 && r.oidx == 2'h0 |=> SO_O == MFR_CODE[7])
        else $error("identity does not open with maker code");

endmodule : spi_flash_cmd_decoder
`default_nettype wire

// ===== bench/spi_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    input wire logic clk_i,
    input wire logic so_i,
    output logic cs_b_o,
    output logic sclk_o,
    output logic si_o
);
    logic cpol;

    // Idle: deselected, clock low between frames until mode() says else
    initial begin
        cpol = 1'b0;
        cs_b_o = 1'b1;
        sclk_o = 1'b0;
        si_o = 1'b0;
    end

    // Eight system cycles per half gives the 160 ns link clock
    task automatic half();
        repeat (8) @(posedge clk_i);
    endtask : half

    task automatic sel();
        @(posedge clk_i);
        cs_b_o <= 1'b0;
        half();
    endtask : sel

    // Moves the idle clock level while deselected, so the edge is ignored
    task automatic mode(input logic p);
        @(posedge clk_i);
        cpol = p;
        sclk_o <= p;
        half();
    endtask : mode

    // SI moves at the falling edge so it is stable at the rise
    task automatic shift(input logic [7:0] d, input int n,
                         output logic [7:0] r);
        r = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            if (cpol) sclk_o <= 1'b0;
            si_o <= d[i];
            half();
            sclk_o <= 1'b1;
            r[i] = so_i;
            half();
            if (!cpol) sclk_o <= 1'b0;
        end
    endtask : shift

    // Released SI shows the inverse so a stale bit is never trusted
    task automatic desel();
        half();
        cs_b_o <= 1'b1;
        si_o <= ~si_o;
        half();
        half();
    endtask : desel
endmodule : spi_host_model
`default_nettype wire

// ===== bench/spi_flash_command_decoder_bench.sv
`timescale 1ns/10ps
`default_nettype none
module spi_flash_command_decoder_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cs_b, sclk, si, so, so_oe, wl, busy, act, slp, start, stb;
    logic [2:0] kind;
    logic [3:0] sector;
    logic [5:0] stat_up = 6'h2a;
    logic [7:0] rd_dat = 8'ha5;
    logic [7:0] wdat;
    logic [23:0] addr;
    logic [23:0] rx;
    logic [7:0] r;
    logic oe_seen, act_seen;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int stbs = 0;
    int starts = 0;
    logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
    logic [2:0] kinds [5] = '{3'h3, 3'h4, 3'h4, 3'h5, 3'h5};

    always #5 clk = ~clk;

    spi_host_model host (.clk_i(clk), .so_i(so), .cs_b_o(cs_b),
        .sclk_o(sclk), .si_o(si));

    // Long busy time so a probe frame fits inside it
    spi_flash_cmd_decoder #(.OP_CYCLES(400)) dut (.CLK_SYS_I(clk),
        .RST_B_I(rst_b), .CS_B_I(cs_b), .SCLK_I(sclk), .SI_I(si),
        .STATUS_UPPER_I(stat_up), .RD_DATA_I(rd_dat), .SO_O(so),
        .SO_OE_O(so_oe), .WRITE_LATCH_O(wl), .BUSY_FLAG_O(busy),
        .ACTIVE_O(act), .SLEEP_O(slp), .OP_START_O(start), .OP_KIND_O(kind),
        .ADDR_O(addr), .SECTOR_O(sector), .WR_DATA_O(wdat), .WR_STB_O(stb));

    task automatic check(input string what, input logic [23:0] seen,
                         input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("Checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    // Whole frame: nb bytes out of tx from the top, then nrd bytes read
    task automatic xact(input logic [31:0] tx, input int nb, input int nrd);
        rx = 24'h000000;
        host.sel();
        for (int k = 0; k < nb; k++)
            host.shift(tx[31 - 8 * k -: 8], 8, r);
        for (int k = 0; k < nrd; k++) begin
            host.shift(8'h00, 8, r);
            rx = {rx[15:0], r};
        end
        host.desel();
    endtask : xact

    // Opcode then one more byte; records whether SO was driven meanwhile
    task automatic probe(input logic [7:0] op);
        host.sel();
        host.shift(op, 8, r);
        host.shift(8'h00, 8, r);
        oe_seen = so_oe;
        act_seen = act;
        host.desel();
    endtask : probe

    // Waits out the busy time, bounded so a stuck flag shows as an error
    task automatic idle();
        for (int w = 0; w < 500 && busy !== 1'b0; w++)
            @(posedge clk);
    endtask : idle

    // Hang guard above the 17000 or so cycles the tests need; also counts
    // strobe and start pulses, each of which stands for one cycle
    always @(posedge clk) begin
        cycles++;
        stbs += (stb === 1'b1);
        starts += (start === 1'b1);
        if (cycles == 30000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check("latch", wl, 1'b0);
        check("so_oe", so_oe, 1'b0);
        xact(32'h06000000, 1, 0);
        check("latch", wl, 1'b1);
        xact(32'h04000000, 1, 0);
        check("latch", wl, 1'b0);
        xact(32'h9f000000, 1, 3);
        check("ident", rx, 24'h5a3c0e);
        check("so_oe", so_oe, 1'b0);
        xact(32'h06000000, 1, 0);
        // Disable with three stray bits after it must be discarded
        host.sel();
        host.shift(8'h04, 8, r);
        host.shift(8'h00, 3, r);
        host.desel();
        check("latch", wl, 1'b1);
        xact(32'h05000000, 1, 1);
        check("status", rx[7:0], {6'h2a, 2'b10});
        probe(8'h77);
        check("so_oe", oe_seen, 1'b0);
        check("active", act_seen, 1'b0);
        probe(8'h05);
        check("active", act_seen, 1'b1);
        check("so_oe", oe_seen, 1'b1);
        // Identity read ended after three bits
        host.sel();
        host.shift(8'h9f, 8, r);
        host.shift(8'h00, 3, r);
        host.desel();
        check("part_id", r[7:5], 3'b010);
        check("so_oe", so_oe, 1'b0);
        for (int i = 0; i < 5; i++) begin
            xact(32'h06000000, 1, 0);
            xact({ops[i], 24'h00a300}, (i < 3) ? 4 : 1, 0);
            check("kind", kind, kinds[i]);
            check("latch", wl, 1'b0);
            check("busy", busy, 1'b1);
            if (i < 3)
                check("sector", sector, 4'ha);
            if (i < 3)
                check("addr", addr, 24'h00a300);
            if (i == 0) begin
                probe(8'h9f);
                check("so_oe", oe_seen, 1'b0);
                check("active", act_seen, 1'b0);
            end
            idle();
            check("busy", busy, 1'b0);
            xact(32'h05000000, 1, 1);
            check("ready", rx[1:0], 2'b00);
        end
        // Nine-byte page frame runs the byte counter to its top
        xact(32'h06000000, 1, 0);
        host.sel();
        host.shift(8'h02, 8, r);
        repeat (3) host.shift(8'h00, 8, r);
        repeat (5) host.shift(8'h3c, 8, r);
        host.desel();
        check("strobes", stbs, 5);
        check("wr_data", wdat, 8'h3c);
        check("kind", kind, 3'h2);
        check("latch", wl, 1'b0);
        idle();
        xact(32'h06000000, 1, 0);
        xact(32'h01770000, 2, 0);
        check("strobes", stbs, 6);
        check("wr_data", wdat, 8'h77);
        check("kind", kind, 3'h1);
        idle();
        // Identity read once more with the clock idling high
        host.mode(1'b1);
        xact(32'h9f000000, 1, 3);
        check("ident_m3", rx, 24'h5a3c0e);
        host.mode(1'b0);
        xact(32'h03001234, 4, 1);
        check("read", rx[7:0], 8'ha5);
        xact(32'h0b001234, 4, 2);
        check("qread", rx[7:0], 8'ha5);
        xact(32'h90000001, 4, 2);
        check("maker", rx[15:0], 16'h0d5a);
        xact(32'h90000000, 4, 2);
        check("maker", rx[15:0], 16'h5a0d);
        xact(32'hb9000000, 1, 0);
        check("sleep", slp, 1'b1);
        probe(8'h05);
        check("active", act_seen, 1'b0);
        xact(32'hab000000, 4, 1);
        check("legacy", rx[7:0], 8'h0d);
        check("sleep", slp, 1'b1);
        xact(32'hab000000, 1, 0);
        check("sleep", slp, 1'b0);
        xact(32'h2000a300, 4, 0);
        check("busy", busy, 1'b0);
        check("starts", starts, 7);
        summarize();
    end
endmodule : spi_flash_command_decoder_bench
`default_nettype wire
